/* rtl/sta_cmd.v */
`timescale 1ns/10ps
`include "sta_defs.vh"

// Notes on behaviour
// - STOP during positioning decelerates, temporary stop
// - GO resumes move from temporary stop
// - CLR ends move, drops remaining distance
// - Forced outputs ignore servo state
// - Mode value 0004 enters forced output
// - Command 92 A0 sets three output pins
// - Mode value 0000 leaves forced output
// - Mode value 0003 enters motorless operation
// - Motorless ignores cancel; only power cycle
// - History alarm numbers, 00FF means none
// - History occurrence hours in whole hours
// - 82 20 1EA5 erases history
// - Current alarm number or 00FF
// - Status snapshot at alarm, items 80-8E
// - 82 00 1EA5 clears alarm like pin
// - Point table position and speed reads
// - Point table accel and decel reads
// - Point table dwell and auxiliary reads
// - Mode values 0001 to 0005 select test
// - Half-second silence in test stops motor
module sta_cmd #(
    parameter WDOG_CYC = `STA_WDOG_MS * (`STA_CLK_HZ / 1000)
) (
    input  wire        MCLK,
    input  wire        RST_N,
    input  wire        CE,
    input  wire        CMD_VALID,
    input  wire [7:0]  CMD_CODE,
    input  wire [7:0]  CMD_DNUM,
    input  wire [31:0] CMD_DATA,
    output reg         CMD_READY,
    output reg         REPLY_VALID,
    output reg         REPLY_ERR,
    output reg  [31:0] REPLY_DATA,
    output reg         AUX_RD,
    output reg  [2:0]  AUX_SEL,
    output reg  [7:0]  AUX_IDX,
    input  wire [31:0] AUX_RDATA,
    input  wire        MOVE_BUSY,
    output reg         POS_HOLD,
    output reg         POS_RESUME,
    output reg         POS_DISCARD,
    output reg         COMM_TIMEOUT,
    output reg  [2:0]  TEST_MODE,
    input  wire        ALARM_EVT,
    input  wire [7:0]  ALARM_NO,
    input  wire [15:0] HOUR_COUNT,
    input  wire        ALARM_CLEAR_INPUT,
    output reg         ALARM_ACTIVE,
    output reg  [7:0]  ALARM_NOW,
    input  wire [2:0]  NORMAL_OUT,
    output reg  [2:0]  OUTPUT_CONNECTOR
);

    // ==========================================================
    // Declarations.
    localparam S_IDLE = 2'b01;
    localparam S_AUX  = 2'b10;
    localparam P_RUN  = 2'b01;
    localparam P_HOLD = 2'b10;

    reg  [1:0]  st_reg;
    reg  [1:0]  pst_reg;
    reg         aux_wait_reg;
    reg  [2:0]  force_reg;
    reg         do_dis_reg;
    reg  [25:0] wdog_reg;
    reg         clr_s1_reg;
    reg         clr_s2_reg;
    reg         clr_s3_reg;
    reg  [7:0]  hist_no [0:`STA_HIST_DEPTH-1];
    reg  [15:0] hist_hr [0:`STA_HIST_DEPTH-1];
    integer     i;

    wire        take     = CE & CMD_VALID & CMD_READY & st_reg[0];
    wire        key_ok   = (CMD_DATA == `STA_KEY_CLEAR);
    wire [3:0]  dn_hi    = CMD_DNUM[7:4];
    wire [3:0]  dn_lo    = CMD_DNUM[3:0];
    wire        dn_pt    = (CMD_DNUM != `STA_DN_ZERO);
    wire        pos_cmd  = take & (CMD_CODE == `STA_CMD_POS_CTRL)
                           & (CMD_DNUM == `STA_DN_POS_CTRL);
    wire        mode_cmd = take & (CMD_CODE == `STA_CMD_TEST_MODE)
                           & (CMD_DNUM == `STA_DN_ZERO);
    wire        clr_pin  = clr_s2_reg & ~clr_s3_reg;
    wire        alm_clr  = (take & (CMD_CODE == `STA_CMD_CLEAR)
                           & (CMD_DNUM == `STA_DN_ZERO) & key_ok) | clr_pin;
    wire        hist_clr = take & (CMD_CODE == `STA_CMD_CLEAR)
                           & (CMD_DNUM == `STA_DN_HIST_CLR) & key_ok;
    wire [2:0]  h_idx    = dn_lo[2:0];

    // ==========================================================
    // Alarm clear pin synchroniser; a rise is detected from the second and third stages.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            clr_s1_reg <= 1'b0;
            clr_s2_reg <= 1'b0;
            clr_s3_reg <= 1'b0;
        end else if (CE) begin
            clr_s1_reg <= ALARM_CLEAR_INPUT;
            clr_s2_reg <= clr_s1_reg;
            clr_s3_reg <= clr_s2_reg;
        end
    end

    // ==========================================================
    // Current alarm and history; a new alarm beats a same-cycle clear so none is lost.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            ALARM_ACTIVE <= 1'b0;
            ALARM_NOW    <= `STA_NO_ALARM;
            for (i = 0; i < `STA_HIST_DEPTH; i = i + 1) begin
                hist_no[i] <= `STA_NO_ALARM;
                hist_hr[i] <= `STA_HR_RESET;
            end
        end else if (CE) begin
            if (ALARM_EVT) begin
                ALARM_ACTIVE <= 1'b1;
                ALARM_NOW    <= ALARM_NO;
            end else if (alm_clr) begin
                ALARM_ACTIVE <= 1'b0;
                ALARM_NOW    <= `STA_NO_ALARM;
            end
            if (ALARM_EVT) begin
                for (i = `STA_HIST_DEPTH - 1; i > 0; i = i - 1) begin
                    hist_no[i] <= hist_clr ? `STA_NO_ALARM : hist_no[i-1];
                    hist_hr[i] <= hist_clr ? `STA_HR_RESET : hist_hr[i-1];
                end
                hist_no[0] <= ALARM_NO;
                hist_hr[0] <= HOUR_COUNT;
            end else if (hist_clr) begin
                for (i = 0; i < `STA_HIST_DEPTH; i = i + 1) begin
                    hist_no[i] <= `STA_NO_ALARM;
                    hist_hr[i] <= `STA_HR_RESET;
                end
            end
        end
    end

    // ==========================================================
    // Test mode; only reset, standing in for a power cycle, ends motorless.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            TEST_MODE <= `STA_MODE_NORMAL;
        end else if (mode_cmd && TEST_MODE != `STA_MODE_MOTORLESS) begin
            // values up to five load as is
            if (CMD_DATA <= {29'h0, `STA_MODE_STEP})
                TEST_MODE <= CMD_DATA[2:0];
        end
    end

    // ==========================================================
    // Forced and normal outputs. Forced pins stay latched between
    // test sessions so a re-entry starts from the last pattern.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            force_reg        <= 3'h0;
            do_dis_reg       <= 1'b0;
            OUTPUT_CONNECTOR <= 3'h0;
        end else if (CE) begin
            if (take && CMD_CODE == `STA_CMD_FORCE_OUT && CMD_DNUM == `STA_DN_FORCE_OUT)
                force_reg <= CMD_DATA[2:0];
            if (take && CMD_CODE == `STA_CMD_IO_EN && key_ok) begin
                if (CMD_DNUM == `STA_DN_DO_DIS)
                    do_dis_reg <= 1'b1;
                else if (CMD_DNUM == `STA_DN_DO_EN)
                    do_dis_reg <= 1'b0;
            end
            if (TEST_MODE == `STA_MODE_FORCE)
                OUTPUT_CONNECTOR <= force_reg;
            else
                OUTPUT_CONNECTOR <= do_dis_reg ? 3'h0 : NORMAL_OUT;
        end
    end

    // ==========================================================
    // Communication watchdog, armed only in a test mode.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            wdog_reg     <= 26'h0;
            COMM_TIMEOUT <= 1'b0;
        end else if (CE) begin
            if (CMD_VALID || TEST_MODE == `STA_MODE_NORMAL) begin
                wdog_reg     <= 26'h0;
                COMM_TIMEOUT <= 1'b0;
            end else if (wdog_reg >= WDOG_CYC[25:0] - 26'h1) begin
                COMM_TIMEOUT <= 1'b1;
            end else begin
                wdog_reg <= wdog_reg + 26'h1;
            end
        end
    end

    // ==========================================================
    // Positioning temporary stop machine.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            pst_reg     <= P_RUN;
            POS_HOLD    <= 1'b0;
            POS_RESUME  <= 1'b0;
            POS_DISCARD <= 1'b0;
        end else if (CE) begin
            POS_RESUME  <= 1'b0;
            POS_DISCARD <= 1'b0;
            case (pst_reg)
                P_RUN: begin
                    // stop during move; only when moving
                    if (pos_cmd && CMD_DATA == `STA_TXT_STOP && MOVE_BUSY
                        && TEST_MODE == `STA_MODE_POSN) begin
                        pst_reg  <= P_HOLD;
                        POS_HOLD <= 1'b1;
                    end
                end
                P_HOLD: begin
                    if (TEST_MODE != `STA_MODE_POSN) begin
                        pst_reg     <= P_RUN;
                        POS_HOLD    <= 1'b0;
                        POS_DISCARD <= 1'b1;
                    end else if (pos_cmd && CMD_DATA == `STA_TXT_GO) begin
                        pst_reg    <= P_RUN;
                        POS_HOLD   <= 1'b0;
                        POS_RESUME <= 1'b1;
                    end else if (pos_cmd && CMD_DATA == `STA_TXT_DISCARD) begin
                        pst_reg     <= P_RUN;
                        POS_HOLD    <= 1'b0;
                        POS_DISCARD <= 1'b1;
                    end
                end
                default: begin
                    pst_reg  <= P_RUN;
                    POS_HOLD <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Reads and replies; table and snapshot data arrive one cycle late.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            st_reg       <= S_IDLE;
            aux_wait_reg <= 1'b0;
            CMD_READY    <= 1'b0;
            REPLY_VALID  <= 1'b0;
            REPLY_ERR    <= 1'b0;
            REPLY_DATA   <= 32'h0;
            AUX_RD       <= 1'b0;
            AUX_SEL      <= `STA_SEL_POS;
            AUX_IDX      <= 8'h0;
        end else if (CE) begin
            REPLY_VALID <= 1'b0;
            AUX_RD      <= 1'b0;
            case (st_reg)
                S_IDLE: begin
                    CMD_READY <= 1'b1;
                    if (take) begin
                        REPLY_VALID <= 1'b1;
                        REPLY_ERR   <= 1'b0;
                        REPLY_DATA  <= 32'h0;
                        case (CMD_CODE)
                            `STA_CMD_ALM_NOW:
                                if (CMD_DNUM == `STA_DN_ZERO)
                                    REPLY_DATA <= {24'h0, ALARM_NOW};
                                else
                                    REPLY_ERR <= 1'b1;
                            `STA_CMD_MODE_RD:
                                if (CMD_DNUM == `STA_DN_MODE_RD)
                                    REPLY_DATA <= {29'h0, TEST_MODE};
                                else
                                    REPLY_ERR <= 1'b1;
                            `STA_CMD_HIST_RD:
                                if (dn_lo > `STA_DN_HIST_MAX)
                                    REPLY_ERR <= 1'b1;
                                else if (dn_hi == `STA_DN_HIST_NO)
                                    REPLY_DATA <= {24'h0, hist_no[h_idx]};
                                else if (dn_hi == `STA_DN_HIST_HR)
                                    REPLY_DATA <= {16'h0, hist_hr[h_idx]};
                                else
                                    REPLY_ERR <= 1'b1;
                            `STA_CMD_SNAP_RD:
                                if (dn_hi == `STA_DN_SNAP && dn_lo <= `STA_DN_SNAP_MAX) begin
                                    REPLY_VALID <= 1'b0;
                                    AUX_RD      <= 1'b1;
                                    AUX_SEL     <= `STA_SEL_SNAP;
                                    AUX_IDX     <= {4'h0, dn_lo};
                                    st_reg      <= S_AUX;
                                    CMD_READY   <= 1'b0;
                                end else
                                    REPLY_ERR <= 1'b1;
                            // position and speed; accel and decel; dwell and auxiliary
                            `STA_CMD_PT_POS, `STA_CMD_PT_SPD, `STA_CMD_PT_ACC,
                            `STA_CMD_PT_DEC, `STA_CMD_PT_DWELL, `STA_CMD_PT_AUX:
                                if (dn_pt) begin
                                    REPLY_VALID <= 1'b0;
                                    AUX_RD      <= 1'b1;
                                    AUX_IDX     <= CMD_DNUM;
                                    st_reg      <= S_AUX;
                                    CMD_READY   <= 1'b0;
                                    case (CMD_CODE)
                                        `STA_CMD_PT_POS: AUX_SEL <= `STA_SEL_POS;
                                        `STA_CMD_PT_SPD: AUX_SEL <= `STA_SEL_SPD;
                                        `STA_CMD_PT_ACC: AUX_SEL <= `STA_SEL_ACC;
                                        `STA_CMD_PT_DEC: AUX_SEL <= `STA_SEL_DEC;
                                        `STA_CMD_PT_DWELL: AUX_SEL <= `STA_SEL_DWELL;
                                        default: AUX_SEL <= `STA_SEL_AUXF;
                                    endcase
                                end else
                                    REPLY_ERR <= 1'b1;
                            `STA_CMD_CLEAR:
                                REPLY_ERR <= ~key_ok;
                            `STA_CMD_TEST_MODE, `STA_CMD_IO_EN,
                            `STA_CMD_FORCE_OUT, `STA_CMD_POS_CTRL:
                                REPLY_ERR <= 1'b0;
                            default:
                                REPLY_ERR <= 1'b1;
                        endcase
                    end
                end
                S_AUX: begin
                    // Data is valid the cycle after the strobe.
                    if (aux_wait_reg) begin
                        aux_wait_reg <= 1'b0;
                        REPLY_VALID  <= 1'b1;
                        REPLY_DATA   <= AUX_RDATA;
                        st_reg       <= S_IDLE;
                        CMD_READY    <= 1'b1;
                    end else begin
                        aux_wait_reg <= 1'b1;
                    end
                end
                default: begin
                    st_reg    <= S_IDLE;
                    CMD_READY <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* rtl/sta_defs.vh */
`ifndef STA_DEFS_VH
`define STA_DEFS_VH
// ==========================================================
// Command codes.
`define STA_CMD_ALM_NOW    8'h02
`define STA_CMD_MODE_RD    8'h00
`define STA_CMD_HIST_RD    8'h33
`define STA_CMD_SNAP_RD    8'h35
`define STA_CMD_PT_POS     8'h40
`define STA_CMD_PT_SPD     8'h50
`define STA_CMD_PT_ACC     8'h54
`define STA_CMD_PT_DEC     8'h58
`define STA_CMD_PT_DWELL   8'h60
`define STA_CMD_PT_AUX     8'h64
`define STA_CMD_CLEAR      8'h82
`define STA_CMD_TEST_MODE  8'h8B
`define STA_CMD_IO_EN      8'h90
`define STA_CMD_FORCE_OUT  8'h92
`define STA_CMD_POS_CTRL   8'hA0
// ==========================================================
// Data numbers.
`define STA_DN_ZERO        8'h00
`define STA_DN_MODE_RD     8'h12
`define STA_DN_HIST_NO     4'h1
`define STA_DN_HIST_HR     4'h2
`define STA_DN_HIST_MAX    4'h5
`define STA_DN_SNAP        4'h8
`define STA_DN_SNAP_MAX    4'hE
`define STA_DN_HIST_CLR    8'h20
`define STA_DN_DO_DIS      8'h03
`define STA_DN_DO_EN       8'h13
`define STA_DN_FORCE_OUT   8'hA0
`define STA_DN_POS_CTRL    8'h41
// ==========================================================
// Data values and texts.
`define STA_KEY_CLEAR      32'h00001EA5
`define STA_TXT_STOP       32'h53544F50
`define STA_TXT_GO         32'h474F2020
`define STA_TXT_DISCARD    32'h434C5220
`define STA_NO_ALARM       8'hFF
`define STA_HR_RESET       16'h0000
`define STA_HIST_DEPTH     6
// ==========================================================
// Test operation modes.
`define STA_MODE_NORMAL    3'h0
`define STA_MODE_JOG       3'h1
`define STA_MODE_POSN      3'h2
`define STA_MODE_MOTORLESS 3'h3
`define STA_MODE_FORCE     3'h4
`define STA_MODE_STEP      3'h5
// ==========================================================
// Auxiliary read selectors.
`define STA_SEL_POS        3'h0
`define STA_SEL_SPD        3'h1
`define STA_SEL_ACC        3'h2
`define STA_SEL_DEC        3'h3
`define STA_SEL_DWELL      3'h4
`define STA_SEL_AUXF       3'h5
`define STA_SEL_SNAP       3'h6
// ==========================================================
// Timing.
`define STA_CLK_HZ         100000000
`define STA_WDOG_MS        500
`endif

/* verification/sta_cmd_props.sv */
`timescale 1ns/10ps
// ==========================================================
// Command port checks, attached to the interpreter top.
module sta_cmd_props (
    input wire        MCLK,
    input wire        RST_N,
    input wire        CE,
    input wire        CMD_VALID,
    input wire        CMD_READY,
    input wire [7:0]  CMD_CODE,
    input wire [7:0]  CMD_DNUM,
    input wire [31:0] CMD_DATA,
    input wire        REPLY_VALID,
    input wire [31:0] REPLY_DATA,
    input wire        AUX_RD,
    input wire [2:0]  AUX_SEL,
    input wire [7:0]  AUX_IDX,
    input wire [31:0] AUX_RDATA,
    input wire        MOVE_BUSY,
    input wire        POS_HOLD,
    input wire        POS_RESUME,
    input wire        POS_DISCARD,
    input wire [2:0]  TEST_MODE,
    input wire        ALARM_EVT,
    input wire        ALARM_ACTIVE,
    input wire [7:0]  ALARM_NOW,
    input wire [2:0]  OUTPUT_CONNECTOR
);
default clocking cb @(posedge MCLK); endclocking
default disable iff (!RST_N);
// Take qualifiers shared by all checks below.
wire       take = CE && CMD_VALID && CMD_READY;
wire       pos  = take && CMD_CODE == 8'hA0 && CMD_DNUM == 8'h41;
wire       mset = take && CMD_CODE == 8'h8B && CMD_DNUM == 8'h00;
wire       pt   = CMD_CODE inside {8'h40, 8'h50, 8'h54, 8'h58, 8'h60, 8'h64};
wire [2:0] fbits = CMD_DATA[2:0];
function automatic [2:0] sel_of(input [7:0] c);
    sel_of = (c == 8'h40) ? 3'h0 : (c == 8'h50) ? 3'h1 : (c == 8'h54) ? 3'h2 :
             (c == 8'h58) ? 3'h3 : (c == 8'h60) ? 3'h4 : 3'h5;
endfunction
sequence s_aux_req;
    AUX_RD && !CMD_READY && AUX_IDX == $past(CMD_DNUM) && AUX_SEL == sel_of($past(CMD_CODE));
endsequence
sequence s_aux_rep;
    REPLY_VALID && REPLY_DATA == $past(AUX_RDATA);
endsequence
property p_aux;
    take && pt && CMD_DNUM != 8'h00 |=> s_aux_req ##2 s_aux_rep;
endproperty
a_aux: assert property (p_aux) else $error("table read sequence wrong");
property p_now;
    take && CMD_CODE == 8'h02 && CMD_DNUM == 8'h00 |=>
        REPLY_VALID && REPLY_DATA == {24'h0, $past(ALARM_NOW)};
endproperty
a_now: assert property (p_now) else $error("current alarm reply wrong");
property p_stop;
    pos && CMD_DATA == 32'h53544F50 && TEST_MODE == 3'h2 && MOVE_BUSY |=> POS_HOLD;
endproperty
a_stop: assert property (p_stop) else $error("stop did not hold");
property p_go;
    pos && CMD_DATA == 32'h474F2020 && POS_HOLD |=> !POS_HOLD && POS_RESUME;
endproperty
a_go: assert property (p_go) else $error("restart not issued");
property p_clr;
    pos && CMD_DATA == 32'h434C5220 && POS_HOLD |=> !POS_HOLD && POS_DISCARD;
endproperty
a_clr: assert property (p_clr) else $error("discard not issued");
property p_idle_go;
    pos && CMD_DATA == 32'h474F2020 && !POS_HOLD |=> !POS_RESUME;
endproperty
a_idle_go: assert property (p_idle_go) else $error("restart outside hold");
property p_mode;
    mset && CMD_DATA inside {[1:5]} && TEST_MODE != 3'h3 |=> TEST_MODE == $past(fbits);
endproperty
a_mode: assert property (p_mode) else $error("test mode not taken");
property p_motorless;
    mset && CMD_DATA == 32'h0 && TEST_MODE == 3'h3 |=> TEST_MODE == 3'h3;
endproperty
a_motorless: assert property (p_motorless) else $error("motorless cancelled");
property p_force;
    take && CMD_CODE == 8'h92 && CMD_DNUM == 8'hA0 && TEST_MODE == 3'h4 |=>
        ##1 OUTPUT_CONNECTOR == $past(fbits, 2);
endproperty
a_force: assert property (p_force) else $error("forced pins wrong");
property p_clear;
    take && CMD_CODE == 8'h82 && CMD_DNUM == 8'h00 && CMD_DATA == 32'h1EA5 && !ALARM_EVT
        |=> !ALARM_ACTIVE && ALARM_NOW == 8'hFF;
endproperty
a_clear: assert property (p_clear) else $error("alarm not cleared");
endmodule

bind sta_cmd sta_cmd_props u_props (
    .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD_CODE(CMD_CODE), .CMD_DNUM(CMD_DNUM), .CMD_DATA(CMD_DATA),
    .REPLY_VALID(REPLY_VALID), .REPLY_DATA(REPLY_DATA), .AUX_RD(AUX_RD), .AUX_SEL(AUX_SEL),
    .AUX_IDX(AUX_IDX), .AUX_RDATA(AUX_RDATA), .MOVE_BUSY(MOVE_BUSY), .POS_HOLD(POS_HOLD),
    .POS_RESUME(POS_RESUME), .POS_DISCARD(POS_DISCARD), .TEST_MODE(TEST_MODE),
    .ALARM_EVT(ALARM_EVT), .ALARM_ACTIVE(ALARM_ACTIVE), .ALARM_NOW(ALARM_NOW),
    .OUTPUT_CONNECTOR(OUTPUT_CONNECTOR));

/* verification/sta_table_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Point table and alarm snapshot storage.
module sta_table_model (
    input  wire        MCLK,
    input  wire        AUX_RD,
    input  wire [2:0]  AUX_SEL,
    input  wire [7:0]  AUX_IDX,
    output reg  [31:0] AUX_RDATA
);
initial AUX_RDATA = 32'hC3A5_0F0F;
// table contents returned
// Data is valid only the cycle after a request; otherwise it toggles so stale use shows.
always @(posedge MCLK) begin
    if (AUX_RD) begin
        AUX_RDATA <= {AUX_SEL, 5'h00, AUX_IDX, 8'h5A, ~AUX_IDX};
    end else begin
        AUX_RDATA <= ~AUX_RDATA;
    end
end
endmodule

/* verification/sta_cmd_bench.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the command interpreter.
module sta_cmd_bench;
reg         MCLK, RST_N, CE, CMD_VALID, MOVE_BUSY, ALARM_EVT, ALARM_CLEAR_INPUT;
reg  [7:0]  CMD_CODE, CMD_DNUM, ALARM_NO, n;
reg  [31:0] CMD_DATA, lf;
reg  [15:0] HOUR_COUNT;
reg  [2:0]  NORMAL_OUT;
wire        CMD_READY, REPLY_VALID, REPLY_ERR, AUX_RD, POS_HOLD, POS_RESUME, POS_DISCARD;
wire        COMM_TIMEOUT, ALARM_ACTIVE;
wire [31:0] REPLY_DATA, AUX_RDATA;
wire [2:0]  AUX_SEL, TEST_MODE, OUTPUT_CONNECTOR;
wire [7:0]  AUX_IDX, ALARM_NOW;
reg         res_seen, dis_seen;
reg  [7:0]  hn[$];
reg  [15:0] hh[$];
integer     err_count, cmp_count, i, k;
// ==========================================================
// Design and table storage.
sta_cmd #(.WDOG_CYC(20)) dut (
    .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
    .CMD_DNUM(CMD_DNUM), .CMD_DATA(CMD_DATA), .CMD_READY(CMD_READY),
    .REPLY_VALID(REPLY_VALID), .REPLY_ERR(REPLY_ERR), .REPLY_DATA(REPLY_DATA),
    .AUX_RD(AUX_RD), .AUX_SEL(AUX_SEL), .AUX_IDX(AUX_IDX), .AUX_RDATA(AUX_RDATA),
    .MOVE_BUSY(MOVE_BUSY), .POS_HOLD(POS_HOLD), .POS_RESUME(POS_RESUME),
    .POS_DISCARD(POS_DISCARD), .COMM_TIMEOUT(COMM_TIMEOUT), .TEST_MODE(TEST_MODE),
    .ALARM_EVT(ALARM_EVT), .ALARM_NO(ALARM_NO), .HOUR_COUNT(HOUR_COUNT),
    .ALARM_CLEAR_INPUT(ALARM_CLEAR_INPUT), .ALARM_ACTIVE(ALARM_ACTIVE),
    .ALARM_NOW(ALARM_NOW), .NORMAL_OUT(NORMAL_OUT), .OUTPUT_CONNECTOR(OUTPUT_CONNECTOR));
sta_table_model u_tbl (.MCLK(MCLK), .AUX_RD(AUX_RD), .AUX_SEL(AUX_SEL),
    .AUX_IDX(AUX_IDX), .AUX_RDATA(AUX_RDATA));
// Free-running 100 MHz clock.
always #5 MCLK = ~MCLK;
// ==========================================================
// Helpers: random source, expected table word, compare, bus cycle.
function [31:0] nxt(input [31:0] x);
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
function [31:0] tbl(input [2:0] s, input [7:0] x);
    tbl = {s, 5'h00, x, 8'h5A, ~x};
endfunction
task chk(input string nm, input [31:0] e, input [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
endtask
// Waits t rising edges, then the usual drive delay.
task tick(input integer t);
    repeat (t) @(posedge MCLK);
    #1;
endtask
// Holds the request until ready is sampled, then waits a bounded time for the reply.
task cmd(input [7:0] c, input [7:0] dn, input [31:0] d, input [31:0] ed, input ee, input cd);
    tick(1);
    CMD_CODE = c;
    CMD_DNUM = dn;
    CMD_DATA = d;
    CMD_VALID = 1'b1;
    k = 0;
    while (CMD_READY !== 1'b1 && k < 9) begin
        tick(1);
        k = k + 1;
    end
    tick(1);
    CMD_VALID = 1'b0;
    k = 0;
    while (REPLY_VALID !== 1'b1 && k < 6) begin
        tick(1);
        k = k + 1;
    end
    res_seen = POS_RESUME;
    dis_seen = POS_DISCARD;
    chk("reply_valid", 32'h1, {31'h0, REPLY_VALID});
    chk("reply_err", {31'h0, ee}, {31'h0, REPLY_ERR});
    if (cd) chk("reply_data", ed, REPLY_DATA);
endtask
// Short forms: a write with no data checked, and a read that must succeed.
task put(input [7:0] c, input [7:0] dn, input [31:0] d);
    cmd(c, dn, d, 32'h0, 1'b0, 1'b0);
endtask
task get(input [7:0] c, input [7:0] dn, input [31:0] ed);
    cmd(c, dn, 32'h0, ed, 1'b0, 1'b1);
endtask
// One random alarm event; the model history shifts.
task alarm;
    lf = nxt(lf);
    ALARM_NO = (lf[7:0] == 8'hFF) ? 8'h32 : lf[7:0];
    HOUR_COUNT = lf[31:16];
    ALARM_EVT = 1'b1;
    hn.push_front(ALARM_NO);
    hh.push_front(HOUR_COUNT);
    hn = hn[0:5];
    hh = hh[0:5];
    tick(1);
    ALARM_EVT = 1'b0;
endtask
task complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask
// Watchdog sized well beyond the few hundred cycles the sequence needs.
initial begin
    #200000;
    err_count = err_count + 1;
    complete_run;
end
// ==========================================================
// Main sequence.
initial begin
    {MCLK, RST_N, CMD_VALID, MOVE_BUSY, ALARM_EVT, ALARM_CLEAR_INPUT} = 6'h00;
    {CMD_CODE, CMD_DNUM, ALARM_NO, CMD_DATA, HOUR_COUNT} = 72'h0;
    CE = 1'b1;
    err_count = 0;
    cmp_count = 0;
    lf = 32'h8A66;
    NORMAL_OUT = lf[2:0] ^ 3'h5;
    for (i = 0; i < 6; i = i + 1) begin
        hn.push_back(8'hFF);
        hh.push_back(16'h0000);
    end
    tick(10);
    RST_N = 1'b1;
    chk("alarm_now", 32'hFF, {24'h0, ALARM_NOW});
    get(8'h02, 8'h00, 32'hFF);
    repeat (7) alarm;
    for (i = 0; i < 6; i = i + 1) begin
        get(8'h33, 8'h10 + i[7:0], {24'h0, hn[i]});
        get(8'h33, 8'h20 + i[7:0], {16'h0, hh[i]});
    end
    cmd(8'h33, 8'h16, 32'h0, 32'h0, 1'b1, 1'b0);
    get(8'h02, 8'h00, {24'h0, hn[0]});
    cmd(8'h82, 8'h00, 32'h1EA4, 32'h0, 1'b1, 1'b0);
    chk("alarm_active", 32'h1, {31'h0, ALARM_ACTIVE});
    cmd(8'h82, 8'h20, 32'h0, 32'h0, 1'b1, 1'b0);
    get(8'h33, 8'h10, {24'h0, hn[0]});
    put(8'h82, 8'h00, 32'h1EA5);
    chk("alarm_now", 32'hFF, {24'h0, ALARM_NOW});
    alarm;
    ALARM_CLEAR_INPUT = 1'b1;
    tick(5);
    chk("pin_clear", 32'h0, {31'h0, ALARM_ACTIVE});
    ALARM_CLEAR_INPUT = 1'b0;
    put(8'h82, 8'h20, 32'h1EA5);
    get(8'h33, 8'h10, 32'hFF);
    get(8'h33, 8'h25, 32'h0);
    // Every table read code, last one at the top point table number.
    for (i = 0; i < 6; i = i + 1) begin
        lf = nxt(lf);
        n = (i == 5) ? 8'hFF : ((lf[7:0] == 8'h00) ? 8'h01 : lf[7:0]);
        k = 48'h6460_5854_5040 >> (8 * i);
        get(k[7:0], n, tbl(i[2:0], n));
    end
    cmd(8'h40, 8'h00, 32'h0, 32'h0, 1'b1, 1'b0);
    for (i = 0; i < 15; i = i + 1) begin
        get(8'h35, 8'h80 + i[7:0], tbl(3'h6, i[7:0]));
    end
    put(8'h8B, 8'h00, 32'h2);
    MOVE_BUSY = 1'b1;
    put(8'hA0, 8'h41, 32'h474F2020);
    chk("idle_resume", 32'h0, {31'h0, res_seen});
    put(8'hA0, 8'h41, 32'h53544F50);
    chk("hold", 32'h1, {31'h0, POS_HOLD});
    put(8'hA0, 8'h41, 32'h474F2020);
    chk("resume", 32'h1, {31'h0, res_seen & ~POS_HOLD});
    put(8'hA0, 8'h41, 32'h53544F50);
    put(8'hA0, 8'h41, 32'h434C5220);
    chk("discard", 32'h1, {31'h0, dis_seen & ~POS_HOLD});
    MOVE_BUSY = 1'b0;
    put(8'hA0, 8'h41, 32'h53544F50);
    chk("no_hold", 32'h0, {31'h0, POS_HOLD});
    // Step mode is entered only after the table reads above.
    for (i = 1; i < 6; i = i + 1) if (i != 3) begin
        put(8'h8B, 8'h00, i);
        chk("mode", i, {29'h0, TEST_MODE});
    end
    put(8'h8B, 8'h00, 32'h6);
    chk("mode_bad", 32'h5, {29'h0, TEST_MODE});
    put(8'h90, 8'h03, 32'h1EA5);
    put(8'h8B, 8'h00, 32'h4);
    lf = nxt(lf);
    put(8'h92, 8'hA0, lf);
    tick(2);
    chk("forced", {29'h0, lf[2:0]}, {29'h0, OUTPUT_CONNECTOR});
    put(8'h8B, 8'h00, 32'h0);
    tick(2);
    chk("out_off", 32'h0, {29'h0, OUTPUT_CONNECTOR | TEST_MODE});
    put(8'h90, 8'h13, 32'h1EA5);
    tick(2);
    chk("out_norm", {29'h0, NORMAL_OUT}, {29'h0, OUTPUT_CONNECTOR});
    put(8'h8B, 8'h00, 32'h3);
    put(8'h8B, 8'h00, 32'h0);
    get(8'h00, 8'h12, 32'h3);
    tick(25);
    chk("timeout", 32'h1, {31'h0, COMM_TIMEOUT});
    RST_N = 1'b0;
    tick(2);
    RST_N = 1'b1;
    tick(2);
    chk("mode_reset", 32'h0, {29'h0, TEST_MODE});
    complete_run;
end
endmodule
